// ===== hw/cencc_top.v
// cencc_top.v - charger event reporting, thermistor monitor control and
// coin-cell backup charger control, with its register file.
// assumes: the serial register port decoder delivers one-cycle read and
// write strobes with address and data; analog comparators arrive
// asynchronously; the charger state code comes from logic on this clock.
`timescale 1ns/10ps
`default_nettype none
`include "cencc_defs.vh"

module cencc_top (
  input  wire                   clock,               // 250 MHz system clock
  input  wire                   rst_n,               // sync reset, active low
  input  wire                   ce,                  // clock enable
  // register port
  input  wire [`CENCC_AW-1:0]   reg_addr,            // register address
  input  wire [`CENCC_DW-1:0]   reg_wdata,           // write data
  input  wire                   reg_wr,              // write strobe
  input  wire                   reg_rd,              // read strobe
  output reg  [`CENCC_DW-1:0]   reg_rdata,           // read data, next cycle
  output reg                    reg_rvalid,          // read data valid pulse
  // charger logic, same clock
  input  wire [3:0]             charger_state_code,  // live charger state
  // analog comparators, asynchronous
  input  wire                   charging_active,     // charge in progress
  input  wire                   temp_too_cold,       // below window low edge
  input  wire                   temp_too_hot,        // above window high edge
  input  wire                   batt_overvolt_cmp,   // vbat over ovp limit
  input  wire                   vbat_above_float,    // vbat over float level
  input  wire                   ichg_below_eoc,      // current under eoc
  input  wire                   input_present_cmp,   // valid charger input
  input  wire                   vbat_above_trickle,  // vbat over trickle
  input  wire                   input_ilim_cmp,      // input current limit
  input  wire                   input_overvolt_cmp,  // input overvoltage
  input  wire                   pwr_node_uv_cmp,     // power node undervolt
  input  wire                   backup_cell_low_cmp, // backup cell < 2.0 V
  // outputs
  output reg                    thermistor_bias_out, // bias switch on
  output reg                    thermistor_cmp_on,   // window comparators on
  output reg                    thermistor_win_chg,  // 1 = charge window
  output reg                    charge_temp_stop,    // stop charging request
  output reg                    backup_charge_on,    // backup charger runs
  output reg  [2:0]             backup_vsel,         // backup charger voltage
  output reg                    backup_disconnect,   // isolate backup cell
  output reg                    irq                  // interrupt to host
);

  // ---------------------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------------------
  wire [`CENCC_NSYNC-1:0] raw_in;   // asynchronous comparator vector
  wire [`CENCC_NSYNC-1:0] sync_in;  // synchronised comparator vector
  wire                    cell_low; // synchronised backup cell low

  assign raw_in[`CENCC_IN_CHARGING]    = charging_active;
  assign raw_in[`CENCC_IN_TOO_COLD]    = temp_too_cold;
  assign raw_in[`CENCC_IN_TOO_HOT]     = temp_too_hot;
  assign raw_in[`CENCC_IN_BATT_OVP]    = batt_overvolt_cmp;
  assign raw_in[`CENCC_IN_ABOVE_FLOAT] = vbat_above_float;
  assign raw_in[`CENCC_IN_BELOW_EOC]   = ichg_below_eoc;
  assign raw_in[`CENCC_IN_INPUT_OK]    = input_present_cmp;
  assign raw_in[`CENCC_IN_ABOVE_TRKL]  = vbat_above_trickle;
  assign raw_in[`CENCC_IN_ILIM]        = input_ilim_cmp;
  assign raw_in[`CENCC_IN_INPUT_OVP]   = input_overvolt_cmp;
  assign raw_in[`CENCC_IN_PWR_UV]      = pwr_node_uv_cmp;

  // all comparators share one bank; the backup cell gets its own flop pair
  cencc_sync #(
    .WIDTH (`CENCC_NSYNC)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .d_in  (raw_in),
    .q_out (sync_in)
  );

  cencc_sync #(
    .WIDTH (1)
  ) u_sync_cell (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .d_in  (backup_cell_low_cmp),
    .q_out (cell_low)
  );

  // ---------------------------------------------------------------------------
  // register file storage
  // ---------------------------------------------------------------------------
  reg [`CENCC_DW-1:0] charger_event_mask_r; // event mask, 1 masks
  reg [`CENCC_DW-1:0] charger_ctrl_r;       // charger control byte
  reg [`CENCC_DW-1:0] discharge_control_r;  // discharge control byte
  reg [`CENCC_DW-1:0] backup_ctrl_r;        // backup cell control byte
  reg [`CENCC_DW-1:0] live_prev_r;          // last cycle live levels
  reg [3:0]           state_prev_r;         // last cycle state code

  wire wr_flags = reg_wr & (reg_addr == `CENCC_ADDR_EVT_FLAGS);
  wire wr_mask  = reg_wr & (reg_addr == `CENCC_ADDR_EVT_MASK);
  wire wr_ctrl  = reg_wr & (reg_addr == `CENCC_ADDR_CHG_CTRL);
  wire wr_dis   = reg_wr & (reg_addr == `CENCC_ADDR_DISCHARGE);
  wire wr_bk    = reg_wr & (reg_addr == `CENCC_ADDR_BACKUP);

  wire state_report_select = charger_ctrl_r[`CENCC_CTRL_STATE_RPT];
  wire thermistor_enable   = discharge_control_r[`CENCC_DIS_THERM_EN];
  wire backup_cell_charge_enable = backup_ctrl_r[`CENCC_BK_ENABLE];
  wire [2:0] backup_cell_voltage_sel =
    backup_ctrl_r[`CENCC_BK_VSEL_HI:`CENCC_BK_VSEL_LO];

  // writes to control registers; status and state are read only
  always @(posedge clock) begin
    if (!rst_n) begin
      charger_event_mask_r <= `CENCC_RST_ZERO8;
      charger_ctrl_r       <= `CENCC_RST_CHG_CTRL;
      discharge_control_r  <= `CENCC_RST_DISCHARGE;
      backup_ctrl_r        <= `CENCC_RST_BACKUP;
    end else if (ce) begin
      if (wr_mask) begin
        // reserved bit 0 stays zero
        charger_event_mask_r <= reg_wdata & `CENCC_EVT_LIVE_MASK;
      end
      if (wr_ctrl) begin
        charger_ctrl_r <= reg_wdata;
      end
      if (wr_dis) begin
        discharge_control_r <= reg_wdata & `CENCC_DIS_WMASK;
      end
      if (wr_bk) begin
        backup_ctrl_r <= reg_wdata & `CENCC_BK_WMASK;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // thermistor monitor
  // ---------------------------------------------------------------------------
  wire charging = sync_in[`CENCC_IN_CHARGING];
  // charging forces the circuit on; the enable bit only counts in discharge
  wire therm_on = charging | thermistor_enable;
  // comparators are only trusted while powered; an unpowered divider
  // would otherwise look like a permanent fault
  wire temp_fault = therm_on &
                    (sync_in[`CENCC_IN_TOO_COLD] |
                     sync_in[`CENCC_IN_TOO_HOT]);

  // ---------------------------------------------------------------------------
  // live condition levels, one bit per event position
  // ---------------------------------------------------------------------------
  wire       done_cond = sync_in[`CENCC_IN_ABOVE_FLOAT] &
                         sync_in[`CENCC_IN_BELOW_EOC];
  wire       state_chg = (charger_state_code != state_prev_r);
  wire [7:0] flags;                                            // latched
  wire [7:0] live;                                             // levels

  assign live[`CENCC_EVT_RSVD]      = 1'b0;
  assign live[`CENCC_EVT_BATT_OVP]  = sync_in[`CENCC_IN_BATT_OVP];
  assign live[`CENCC_EVT_TEMP]      = temp_fault;
  // with state reporting, the done level follows the pending flag
  assign live[`CENCC_EVT_DONE]      = state_report_select ?
                                      flags[`CENCC_EVT_DONE] :
                                      done_cond;
  assign live[`CENCC_EVT_INPUT_DET] = sync_in[`CENCC_IN_INPUT_OK];
  assign live[`CENCC_EVT_BATT_DET]  = sync_in[`CENCC_IN_ABOVE_TRKL];
  assign live[`CENCC_EVT_ILIM]      = sync_in[`CENCC_IN_ILIM];
  assign live[`CENCC_EVT_INPUT_OVP] = sync_in[`CENCC_IN_INPUT_OVP];

  // ---------------------------------------------------------------------------
  // event detection: rising edges, or both edges for the detect bits, or any state code change for done with state reporting
  // ---------------------------------------------------------------------------
  wire [7:0] rise = live & ~live_prev_r;  // level just rose
  wire [7:0] edg  = live ^ live_prev_r;   // level just changed
  wire [7:0] set_vec;                     // flag set pulses

  assign set_vec[`CENCC_EVT_RSVD]      = 1'b0;
  assign set_vec[`CENCC_EVT_BATT_OVP]  = rise[`CENCC_EVT_BATT_OVP];
  assign set_vec[`CENCC_EVT_TEMP]      = rise[`CENCC_EVT_TEMP];
  assign set_vec[`CENCC_EVT_DONE]      = state_report_select ?
                                         state_chg :
                                         (done_cond &
                                          ~live_prev_r[`CENCC_EVT_DONE]);
  assign set_vec[`CENCC_EVT_INPUT_DET] = edg[`CENCC_EVT_INPUT_DET];
  assign set_vec[`CENCC_EVT_BATT_DET]  = edg[`CENCC_EVT_BATT_DET];
  assign set_vec[`CENCC_EVT_ILIM]      = rise[`CENCC_EVT_ILIM];
  assign set_vec[`CENCC_EVT_INPUT_OVP] = rise[`CENCC_EVT_INPUT_OVP];

  // history of live levels and state code for edge detection
  always @(posedge clock) begin
    if (!rst_n) begin
      live_prev_r  <= `CENCC_RST_ZERO8;
      state_prev_r <= `CENCC_RST_STATE4;
    end else if (ce) begin
      // done history always tracks the raw completion condition
      live_prev_r  <= {live[7:4], done_cond, live[2:0]};
      state_prev_r <= charger_state_code;
    end
  end

  // ---------------------------------------------------------------------------
  // sticky flags, cleared by writing ones to the flag register
  // ---------------------------------------------------------------------------
  wire [7:0] clr_vec = wr_flags ? reg_wdata : `CENCC_RST_ZERO8;

  cencc_flags #(
    .WIDTH (8)
  ) u_flags (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .set   (set_vec),
    .clr   (clr_vec),
    .flags (flags)
  );

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  reg [`CENCC_DW-1:0] rd_mux;  // selected read value
  always @* begin
    case (reg_addr)
      `CENCC_ADDR_EVT_FLAGS: rd_mux = flags;
      `CENCC_ADDR_EVT_MASK:  rd_mux = charger_event_mask_r;
      `CENCC_ADDR_LIVE_STAT: rd_mux = live;
      `CENCC_ADDR_CHG_STATE: rd_mux = {4'h0, charger_state_code};
      `CENCC_ADDR_CHG_CTRL:  rd_mux = charger_ctrl_r;
      `CENCC_ADDR_DISCHARGE: rd_mux = discharge_control_r;
      `CENCC_ADDR_BACKUP:    rd_mux = backup_ctrl_r;
      // unmapped addresses read as zero
      default:               rd_mux = `CENCC_RST_ZERO8;
    endcase
  end

  // read data registered one cycle after the strobe
  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata  <= `CENCC_RST_ZERO8;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------------------
  // every output leaves from a flop, one cycle after its cause
  always @(posedge clock) begin
    if (!rst_n) begin
      thermistor_bias_out <= 1'b0;
      thermistor_cmp_on   <= 1'b0;
      thermistor_win_chg  <= 1'b0;
      charge_temp_stop    <= 1'b0;
      backup_charge_on    <= 1'b0;
      backup_vsel         <= 3'h0;
      backup_disconnect   <= 1'b0;
      irq                 <= 1'b0;
    end else if (ce) begin
      // bias switch and comparators always move together
      thermistor_bias_out <= therm_on;
      thermistor_cmp_on   <= therm_on;
      // window choice: charge 0..45, discharge -10..60
      thermistor_win_chg  <= charging;
      // only a charging fault stops the charger
      charge_temp_stop    <= charging & temp_fault;
      // backup charger halts below the power node falling threshold
      backup_charge_on    <= backup_cell_charge_enable &
                             ~sync_in[`CENCC_IN_PWR_UV];
      backup_vsel         <= backup_cell_voltage_sel;
      // a low cell is cut off; the backup charger and backup_vsel carry on unchanged
      backup_disconnect   <= cell_low;
      irq                 <= |(flags & ~charger_event_mask_r);
    end
  end

endmodule

`default_nettype wire

// ===== hw/cencc_defs.vh
// cencc_defs.vh - register map, field positions and reset values of the
// charger event, thermistor and backup-cell control block.
// assumes: included by bare name from the top-level design file and the bench files.
`ifndef CENCC_DEFS_VH
`define CENCC_DEFS_VH

// ---------------------------------------------------------------------------
// register offsets on the serial register port (9-bit address)
// ---------------------------------------------------------------------------
`define CENCC_AW              9
`define CENCC_DW              8
`define CENCC_ADDR_EVT_FLAGS  9'h0_D0
`define CENCC_ADDR_EVT_MASK   9'h0_D1
`define CENCC_ADDR_LIVE_STAT  9'h0_D2
`define CENCC_ADDR_CHG_STATE  9'h0_D3
`define CENCC_ADDR_CHG_CTRL   9'h0_D4
`define CENCC_ADDR_DISCHARGE  9'h0_DC
`define CENCC_ADDR_BACKUP     9'h1_D1

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define CENCC_RST_ZERO8       8'h00
`define CENCC_RST_CHG_CTRL    8'hA1
`define CENCC_RST_DISCHARGE   8'h04
`define CENCC_RST_BACKUP      8'h13
`define CENCC_RST_STATE4      4'h0

// ---------------------------------------------------------------------------
// event / mask / status bit positions
// ---------------------------------------------------------------------------
`define CENCC_EVT_RSVD        0
`define CENCC_EVT_BATT_OVP    1
`define CENCC_EVT_TEMP        2
`define CENCC_EVT_DONE        3
`define CENCC_EVT_INPUT_DET   4
`define CENCC_EVT_BATT_DET    5
`define CENCC_EVT_ILIM        6
`define CENCC_EVT_INPUT_OVP   7
// bit 0 is reserved: it never sets and can never be masked
`define CENCC_EVT_LIVE_MASK   8'hFE

// ---------------------------------------------------------------------------
// control fields
// ---------------------------------------------------------------------------
`define CENCC_CTRL_STATE_RPT  3
`define CENCC_DIS_THERM_EN    2
`define CENCC_DIS_WMASK       8'h04
`define CENCC_BK_ENABLE       1
`define CENCC_BK_VSEL_LO      2
`define CENCC_BK_VSEL_HI      4
`define CENCC_BK_WMASK        8'h7F

// ---------------------------------------------------------------------------
// synchronised comparator input vector positions
// ---------------------------------------------------------------------------
`define CENCC_NSYNC           11
`define CENCC_IN_CHARGING     0
`define CENCC_IN_TOO_COLD     1
`define CENCC_IN_TOO_HOT      2
`define CENCC_IN_BATT_OVP     3
`define CENCC_IN_ABOVE_FLOAT  4
`define CENCC_IN_BELOW_EOC    5
`define CENCC_IN_INPUT_OK     6
`define CENCC_IN_ABOVE_TRKL   7
`define CENCC_IN_ILIM         8
`define CENCC_IN_INPUT_OVP    9
`define CENCC_IN_PWR_UV       10

`endif

// ===== hw/cencc_sync.v
// cencc_sync.v - two-flop synchroniser bank for asynchronous comparator
// levels.
// assumes: one clock, synchronous active-low reset, clock enable.
`timescale 1ns/10ps
`default_nettype none

module cencc_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock,  // system clock
  input  wire             rst_n,  // synchronous reset, active low
  input  wire             ce,     // clock enable, freezes state when low
  input  wire [WIDTH-1:0] d_in,   // asynchronous levels
  output wire [WIDTH-1:0] q_out   // synchronised levels
);

  // ---------------------------------------------------------------------------
  // per-bit two stage chain
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_r;  // first stage, read only by second stage
      reg sync_r;  // second stage, safe to use
      always @(posedge clock) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else if (ce) begin
          meta_r <= d_in[gi];
          sync_r <= meta_r;
        end
      end
      assign q_out[gi] = sync_r;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== hw/cencc_flags.v
// cencc_flags.v - sticky event flag bank, write-one-to-clear.
// assumes: set and clear vectors are single-cycle terms on the same clock.
`timescale 1ns/10ps
`default_nettype none

module cencc_flags #(
  parameter WIDTH = 8
) (
  input  wire             clock,  // system clock
  input  wire             rst_n,  // synchronous reset, active low
  input  wire             ce,     // clock enable
  input  wire [WIDTH-1:0] set,    // event pulses
  input  wire [WIDTH-1:0] clr,    // clear pulses from the host
  output wire [WIDTH-1:0] flags   // latched flags
);

  // ---------------------------------------------------------------------------
  // one latch per event bit
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_flag
      reg flag_r;  // latched event
      // set wins over a clear in the same cycle so no event is lost
      always @(posedge clock) begin
        if (!rst_n) begin
          flag_r <= 1'b0;
        end else if (ce) begin
          flag_r <= set[gi] | (flag_r & ~clr[gi]);
        end
      end
      assign flags[gi] = flag_r;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== tb/cencc_props.sv
// cencc_props.sv - port-level timing checks for cencc_top.
// assumes: bound to cencc_top, ce held high, inputs change after edges.
`timescale 1ns/10ps
`default_nettype none
`include "cencc_defs.vh"

module cencc_props (
  input wire       clock,               // system clock
  input wire       rst_n,               // sync reset, low
  input wire [8:0] reg_addr,            // register address
  input wire [7:0] reg_wdata,           // write data
  input wire       reg_wr,              // write strobe
  input wire       reg_rd,              // read strobe
  input wire [7:0] reg_rdata,           // read data
  input wire       reg_rvalid,          // read valid
  input wire       charging_active,     // charge running
  input wire       pwr_node_uv_cmp,     // power undervolt
  input wire       backup_cell_low_cmp, // backup cell low
  input wire       thermistor_bias_out, // bias switch
  input wire       thermistor_cmp_on,   // comparators on
  input wire       thermistor_win_chg,  // charge window
  input wire       charge_temp_stop,    // stop charge
  input wire       backup_charge_on,    // backup charger
  input wire [2:0] backup_vsel,         // backup voltage
  input wire       backup_disconnect,   // cell isolated
  input wire       irq                  // host interrupt
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----
  // single-cycle register write sequences
  // ----
  sequence mask_all_s;
    reg_wr && reg_addr == `CENCC_ADDR_EVT_MASK && reg_wdata == 8'hFF;
  endsequence
  sequence therm_off_s;
    reg_wr && reg_addr == `CENCC_ADDR_DISCHARGE && !reg_wdata[2];
  endsequence
  sequence bk_wr_s;
    reg_wr && reg_addr == `CENCC_ADDR_BACKUP;
  endsequence

  // ----
  // assertions
  // ----
  therm_pair_a: assert property (thermistor_bias_out == thermistor_cmp_on)
    else $error("bias and comparator enables differ");
  therm_off_a: assert property (!charging_active[*4] ##0 therm_off_s
    ##1 !charging_active |=> !thermistor_bias_out)
    else $error("thermistor on after disable");
  win_chg_a: assert property (charging_active[*3] |=>
    thermistor_win_chg && thermistor_bias_out)
    else $error("charge window not forced on");
  win_dis_a: assert property (!charging_active[*3] |=> !thermistor_win_chg)
    else $error("charge window while discharging");
  temp_stop_a: assert property (charge_temp_stop |-> thermistor_win_chg)
    else $error("charge stop outside charging");
  vsel_follow_a: assert property (bk_wr_s |=> ##1
    backup_vsel == $past(reg_wdata[4:2], 2))
    else $error("backup voltage not written");
  uv_halt_a: assert property (pwr_node_uv_cmp[*3] |=> !backup_charge_on)
    else $error("backup charger runs under undervoltage");
  cell_iso_a: assert property (backup_cell_low_cmp[*3] |=> backup_disconnect)
    else $error("low backup cell not isolated");
  irq_mask_a: assert property (mask_all_s |=> ##1 !irq)
    else $error("irq with all events masked");
  rvalid_set_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read without valid pulse");
  rvalid_only_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("valid pulse without read");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule

bind cencc_top cencc_props u_props (.*);
`default_nettype wire

// ===== tb/cencc_host.sv
// cencc_host.sv - host side of the register port, one strobe per access.
// assumes: strobes are sampled on the rising edge after they are raised.
`timescale 1ns/10ps
`default_nettype none

module cencc_host (
  input  wire        clock,      // system clock
  input  wire  [7:0] reg_rdata,  // read data
  input  wire        reg_rvalid, // read valid pulse
  output logic [8:0] reg_addr,   // address, garbled when idle
  output logic [7:0] reg_wdata,  // write data, garbled when idle
  output logic       reg_wr = 0, // write strobe
  output logic       reg_rd = 0  // read strobe
);
  // idle bus never repeats the last value, so stale data cannot pass
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_addr  <= ~a;
    reg_wdata <= ~d;
    reg_wr    <= 1'b0;
  endtask

  // data and valid are taken one edge after the read strobe is taken
  task automatic rd(input logic [8:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_addr <= ~a;
    reg_rd   <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
`default_nettype wire

// ===== tb/cencc_top_tb.sv
// cencc_top_tb.sv - self-checking bench for cencc_top with a host model.
// assumes: cencc_props is bound to the design; ce stays high.
`timescale 1ns/10ps
`default_nettype none
`include "cencc_defs.vh"

module cencc_top_tb;
  logic        clock = 0; // 250 MHz clock
  logic        rst_n = 0; // sync reset
  logic [11:0] cmp = 0; // comparator levels
  logic  [3:0] st_code = 0; // charger state code
  logic  [7:0] rdata, b, m, d; // read data and scratch
  logic  [8:0] addr; // register address
  logic  [7:0] wdata; // write data
  logic        wr, rd, rvalid; // port strobes
  logic        bias, cmp_on, win, stop; // thermistor outputs
  logic        bk_on, bk_dis, irq; // backup and interrupt
  logic  [2:0] vsel; // backup voltage
  logic [31:0] seed = 32'h24af_1b67; // fixed random seed
  int          bad_count, n_checks, cyc; // run counters
  int          ev_in[6] = '{3, 1, 6, 7, 8, 9}; // event comparator index
  int          ev_bit[6] = '{1, 2, 4, 5, 6, 7}; // event flag bit
  logic  [8:0] ra[7] = '{9'h0_D0, 9'h0_D1, 9'h0_D2, 9'h0_D3, 9'h0_D4,
                         9'h0_DC, 9'h1_D1}; // reset-value table
  logic  [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hA1, 8'h04, 8'h13};

  always #2 clock = ~clock;

  cencc_top dut (.clock(clock), .rst_n(rst_n), .ce(1'b1), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .charger_state_code(st_code),
    .charging_active(cmp[0]), .temp_too_cold(cmp[1]), .temp_too_hot(cmp[2]),
    .batt_overvolt_cmp(cmp[3]), .vbat_above_float(cmp[4]),
    .ichg_below_eoc(cmp[5]), .input_present_cmp(cmp[6]),
    .vbat_above_trickle(cmp[7]), .input_ilim_cmp(cmp[8]),
    .input_overvolt_cmp(cmp[9]), .pwr_node_uv_cmp(cmp[10]),
    .backup_cell_low_cmp(cmp[11]), .thermistor_bias_out(bias),
    .thermistor_cmp_on(cmp_on), .thermistor_win_chg(win),
    .charge_temp_stop(stop), .backup_charge_on(bk_on), .backup_vsel(vsel),
    .backup_disconnect(bk_dis), .irq(irq));
  cencc_host u_host (.clock(clock), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));

  // ----
  // expectation helpers and compare tasks
  // ----
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] exp_irq(input logic [7:0] f, input logic [7:0] k);
    return {7'h00, |(f & ~k)};           // any pending unmasked event
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] g;
    logic       v;
    u_host.rd(a, g, v);
    chk("rvalid", 8'h01, {7'h00, v});
    chk("rdata", e, g);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, run takes about 460 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ----
  // main sequence
  // ----
  initial begin
    idle(4);
    rst_n <= 1'b1;
    idle(2);
    for (int i = 0; i < 7; i++) rchk(ra[i], rv[i]);
    chk("bias", 8'h01, {7'h00, bias});
    chk("vsel", 8'h04, {5'h00, vsel});
    u_host.wr(`CENCC_ADDR_EVT_MASK, 8'hFF);
    rchk(`CENCC_ADDR_EVT_MASK, 8'hFE);
    u_host.wr(`CENCC_ADDR_EVT_MASK, 8'h00);
    for (int i = 0; i < 6; i++) begin
      b = 8'h01 << ev_bit[i];
      cmp[ev_in[i]] <= 1'b1;
      idle(6);
      rchk(`CENCC_ADDR_EVT_FLAGS, b);
      rchk(`CENCC_ADDR_LIVE_STAT, b);
      chk("irq", 8'h01, {7'h00, irq});
      chk("stop", 8'h00, {7'h00, stop});
      u_host.wr(`CENCC_ADDR_EVT_FLAGS, b);
      rchk(`CENCC_ADDR_EVT_FLAGS, 8'h00);
      cmp[ev_in[i]] <= 1'b0;
      idle(6);
      rchk(`CENCC_ADDR_EVT_FLAGS, (ev_bit[i] == 4 || ev_bit[i] == 5) ? b : 8'h00);
      u_host.wr(`CENCC_ADDR_EVT_FLAGS, b);
    end
    u_host.wr(`CENCC_ADDR_DISCHARGE, 8'h00);
    cmp[1] <= 1'b1;
    idle(6);
    rchk(`CENCC_ADDR_EVT_FLAGS, 8'h00);
    cmp[0] <= 1'b1;
    idle(6);
    chk("bias", 8'h01, {7'h00, bias});
    chk("stop", 8'h01, {7'h00, stop});
    rchk(`CENCC_ADDR_EVT_FLAGS, 8'h04);
    cmp[1:0] <= 2'b00;
    idle(6);
    chk("bias", 8'h00, {7'h00, bias});
    u_host.wr(`CENCC_ADDR_EVT_FLAGS, 8'h04);
    u_host.wr(`CENCC_ADDR_DISCHARGE, 8'h04);
    cmp[5:4] <= 2'b11;
    idle(6);
    rchk(`CENCC_ADDR_EVT_FLAGS, 8'h08);
    rchk(`CENCC_ADDR_LIVE_STAT, 8'h08);
    u_host.wr(`CENCC_ADDR_EVT_FLAGS, 8'h08);
    cmp[5:4] <= 2'b00;
    st_code <= 4'h7;
    idle(6);
    rchk(`CENCC_ADDR_EVT_FLAGS, 8'h00);
    u_host.wr(`CENCC_ADDR_CHG_CTRL, 8'hA9);
    st_code <= 4'hA;
    idle(4);
    rchk(`CENCC_ADDR_CHG_STATE, 8'h0A);
    rchk(`CENCC_ADDR_EVT_FLAGS, 8'h08);
    rchk(`CENCC_ADDR_LIVE_STAT, 8'h08);
    u_host.wr(`CENCC_ADDR_EVT_FLAGS, 8'h08);
    rchk(`CENCC_ADDR_LIVE_STAT, 8'h00);
    cmp[10] <= 1'b1;
    idle(6);
    chk("bk_on", 8'h00, {7'h00, bk_on});
    cmp[11:10] <= 2'b10;
    idle(6);
    chk("bk_dis", 8'h01, {7'h00, bk_dis});
    chk("bk_on", 8'h01, {7'h00, bk_on});
    cmp[11] <= 1'b0;
    cmp[3] <= 1'b1;
    cmp[8] <= 1'b1;
    idle(6);
    u_host.wr(`CENCC_ADDR_LIVE_STAT, 8'hFF);
    rchk(`CENCC_ADDR_LIVE_STAT, 8'h42);
    rchk(9'h0_55, 8'h00);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      m = seed[7:0];
      d = seed[15:8];
      u_host.wr(`CENCC_ADDR_EVT_MASK, m);
      rchk(`CENCC_ADDR_EVT_MASK, m & 8'hFE);
      chk("irq", exp_irq(8'h42, m), {7'h00, irq});
      u_host.wr(`CENCC_ADDR_BACKUP, d);
      rchk(`CENCC_ADDR_BACKUP, d & 8'h7F);
      chk("vsel", {5'h00, d[4:2]}, {5'h00, vsel});
      chk("bk_on", {7'h00, d[1]}, {7'h00, bk_on});
    end
    u_host.wr(`CENCC_ADDR_BACKUP, 8'h13);
    give_verdict();
  end
endmodule
`default_nettype wire
